// ### logic/scrfe_pkg.sv
// package for the serial command front end: constants, field layout, types
// assumes a 50 MHz system clock and a host-driven serial clock sampled as data
package scrfe_pkg;
	localparam logic [1:0] ADDR_COMMAND = 2'h0; // command on write, status on read
	localparam logic [1:0] ADDR_MODE    = 2'h1; // mode register
	localparam logic [1:0] ADDR_FILTER  = 2'h2; // filter register
	localparam logic [1:0] ADDR_DATA    = 2'h3; // data register
	localparam logic [7:0] CMD_RESET    = 8'h00; // command register after reset
	localparam logic [5:0] ONES_LIMIT   = 6'h20; // ones that force a full reset
	localparam logic [4:0] LEN_SHORT    = 5'h08; // bits of 8-bit registers
	localparam logic [4:0] LEN_DATA     = 5'h18; // bits of the data register
	localparam logic [5:0] EXIT_PATTERN = 6'h0e; // upper six bits of exit command
	localparam int         POS_WEN      = 7;     // write enable bit position
	localparam int         POS_ZERO     = 6;     // must-be-zero bit position
	localparam int         POS_RSHI     = 5;     // reg_select_hi position
	localparam int         POS_RSLO     = 4;     // reg_select_lo position
	localparam int         POS_RW       = 3;     // direction bit position
	localparam int         POS_STREAM   = 2;     // stream_read_bit position
	localparam int         POS_INHI     = 1;     // input_select_hi position
	localparam int         POS_INLO     = 0;     // input_select_lo position
	localparam logic [1:0] CH_DIFF      = 2'h0;  // differential_input_pair
	localparam logic [1:0] CH_SINGLE    = 2'h1;  // single_ended_input
	localparam logic [1:0] CH_SHORT     = 2'h2;  // internal short of negative input
	localparam logic [1:0] CH_SUPPLY    = 2'h3;  // supply monitor, fifth of supply

	// interface states, gray coded along idle -> command -> access
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00, // waiting for a zero in the write enable position
		ST_CMD    = 2'b01, // shifting the remaining seven command bits
		ST_ACCESS = 2'b11, // one register access in progress
		ST_STREAM = 2'b10  // continuous read of the data register
	} scrfe_state_type;

	// decoded command fields
	typedef struct packed {
		logic [1:0] regSel;    // target register address
		logic       readDir;   // 1 read, 0 write
		logic       streamRd;  // continuous read request
		logic [1:0] inputSel;  // analog input choice
	} scrfe_cmd_type;

	// synchronised serial pins with edge marks
	typedef struct packed {
		logic sclkRise; // rising serial clock edge seen
		logic sclkFall; // falling serial clock edge seen
		logic din;      // synchronised serial input
		logic csN;      // synchronised chip select, active low
	} scrfe_pins_type;
endpackage

// ### logic/scrfe_pin_sync.sv
// two-flop synchroniser and edge finder for the serial pins
// assumes pins are asynchronous to clock; the serial clock is slow (160 ns)
`timescale 1ns/1ps
`default_nettype none
module scrfe_pin_sync (
	input  wire logic                clock,  // system clock
	input  wire logic                rst_n,  // asynchronous reset, active low
	input  wire logic                enable, // clock enable
	input  wire logic                sclk,   // serial clock pin
	input  wire logic                din,    // serial data pin
	input  wire logic                csN,    // chip select pin, active low
	output scrfe_pkg::scrfe_pins_type pins   // synchronised pins and edges
);
	typedef struct packed {
		logic [2:0] first;  // first stage, read only by second
		logic [2:0] second; // second stage {sclk, din, csN}
		logic       sclkOld; // previous synchronised serial clock
	} scrfe_sync_type;

	scrfe_sync_type state_reg;  // registered state
	scrfe_sync_type state_next; // next state

	// shift the pins through both stages
	always_comb begin
		state_next = state_reg;
		if (enable) begin
			state_next.first   = {sclk, din, csN};
			state_next.second  = state_reg.first;
			state_next.sclkOld = state_reg.second[2];
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= '{first: 3'h7, second: 3'h7, sclkOld: 1'b1};
		end else begin
			state_reg <= state_next;
		end
	end

	// edge marks only from the second stage
	assign pins.sclkRise = state_reg.second[2] & ~state_reg.sclkOld;
	assign pins.sclkFall = ~state_reg.second[2] & state_reg.sclkOld;
	assign pins.din      = state_reg.second[1];
	assign pins.csN      = state_reg.second[0];
endmodule
`default_nettype wire

// ### logic/scrfe_front_end.sv
// serial command front end: command decode, access sequencing, streaming, 32-ones reset
// assumes the host drives the serial clock idle high and sends commands on its rising edges
`timescale 1ns/1ps
`default_nettype none
module scrfe_front_end (
	input  wire logic        clock,          // 50 MHz system clock
	input  wire logic        rst_n,          // asynchronous reset, active low
	input  wire logic        enable,         // clock enable, freezes all state except the restart, write and reset pulses, which clear
	input  wire logic        sclk,           // serial clock pin from host
	input  wire logic        din,            // serial data pin from host
	input  wire logic        csN,            // chip select pin, active low
	input  wire logic        convDone,       // one-cycle pulse, new conversion result
	input  wire logic        resultStale,    // pulse, result about to be replaced
	input  wire logic [7:0]  statusValue,    // status register contents
	input  wire logic [7:0]  modeValue,      // mode register contents
	input  wire logic [7:0]  filterValue,    // filter register contents
	input  wire logic [23:0] dataValue,      // data register contents
	output logic             doutRdy,        // combined data out / ready pin level
	output logic             doutOe,         // pin enable, high while chip selected
	output logic [7:0]       commandReg,     // command register, to internal logic
	output logic [1:0]       inputSel,       // analog input selection
	output logic             supplyMonitor,  // fifth of supply with internal reference
	output logic             filterRestart,  // pulse: filter reset, new conversion
	output logic             streamActive,   // continuous read mode flag
	output logic             writeStrobe,    // pulse: register write done
	output logic [1:0]       writeAddr,      // address of the written register
	output logic [7:0]       writeData,      // byte written
	output logic             partReset       // pulse: full reset after 32 ones
);
	typedef struct packed {
		scrfe_pkg::scrfe_state_type fsm;      // interface state
		logic [7:0]  cmd;                     // command register
		logic [23:0] shiftOut;                // output shift register
		logic [7:0]  shiftIn;                 // input shift register
		logic [4:0]  bitCount;                // bits moved in this phase
		logic [5:0]  onesCount;               // consecutive high input bits
		logic        rdyN;                    // ready level, low = result waiting
		logic        dout;                    // pin data level
		logic        oe;                      // pin enable
		logic [1:0]  inSel;                   // current analog input
		logic        supply;                  // supply monitor select
		logic        restart;                 // filter restart pulse
		logic        wrStb;                   // write strobe
		logic [1:0]  wrAddr;                  // write address
		logic [7:0]  wrData;                  // write data
		logic        rstPulse;                // full reset pulse
		logic        outActive;               // shifting a read out
	} scrfe_fe_type;

	scrfe_pkg::scrfe_pins_type pins;          // synchronised pins
	scrfe_fe_type              state_reg;     // registered state
	scrfe_fe_type              state_next;    // next state
	scrfe_pkg::scrfe_cmd_type  newCmd;        // fields of the byte just completed
	logic [7:0]                fullByte;      // completed input byte
	logic [4:0]                readLen;       // length of the addressed register

	// pin synchroniser and serial edge finder
	scrfe_pin_sync syncPins (
		.clock  (clock),
		.rst_n  (rst_n),
		.enable (enable),
		.sclk   (sclk),
		.din    (din),
		.csN    (csN),
		.pins   (pins)
	);

	// the byte as it stands once the current bit is shifted in, msb first
	assign fullByte = {state_reg.shiftIn[6:0], pins.din};
	assign newCmd   = '{regSel:   fullByte[scrfe_pkg::POS_RSHI:scrfe_pkg::POS_RSLO],
	                    readDir:  fullByte[scrfe_pkg::POS_RW],
	                    streamRd: fullByte[scrfe_pkg::POS_STREAM],
	                    inputSel: fullByte[scrfe_pkg::POS_INHI:scrfe_pkg::POS_INLO]};
	// data register is 24 bits, the others 8
	assign readLen  = (state_reg.cmd[scrfe_pkg::POS_RSHI:scrfe_pkg::POS_RSLO]
	                   == scrfe_pkg::ADDR_DATA) ? scrfe_pkg::LEN_DATA : scrfe_pkg::LEN_SHORT;

	// next state of the whole front end
	always_comb begin
		state_next          = state_reg;
		state_next.restart  = 1'b0;
		state_next.wrStb    = 1'b0;
		state_next.rstPulse = 1'b0;
		if (enable) begin
			// ready goes low on a fresh result, high again before the next update
			if (convDone) begin
				state_next.rdyN = 1'b0;
			end else if (resultStale) begin
				state_next.rdyN = 1'b1;
			end
			state_next.oe = ~pins.csN;
			// outside a read the pin shows the ready level
			if (!state_reg.outActive) begin
				state_next.dout = state_next.rdyN;
			end
			// output bits change only on falling serial edges
			if (pins.sclkFall && !pins.csN && state_reg.outActive) begin
				state_next.dout     = state_reg.shiftOut[23];
				state_next.shiftOut = {state_reg.shiftOut[22:0], 1'b0};
			end
			if (pins.sclkRise && !pins.csN) begin
				// count consecutive ones on rising edges
				if (pins.din) begin
					state_next.onesCount = state_reg.onesCount + 6'h01;
				end else begin
					state_next.onesCount = 6'h00;
				end
				state_next.shiftIn = fullByte;
				case (state_reg.fsm)
					scrfe_pkg::ST_IDLE: begin
						// a leading one keeps the interface at the first position
						if (!pins.din) begin
							state_next.fsm      = scrfe_pkg::ST_CMD;
							state_next.bitCount = 5'h01;
						end
					end
					scrfe_pkg::ST_CMD: begin
						state_next.bitCount = state_reg.bitCount + 5'h01;
						if (state_reg.bitCount == scrfe_pkg::LEN_SHORT - 5'h01) begin
							// seven bits after the enable bit load the command
							state_next.cmd      = {1'b0, fullByte[6:0]};
							state_next.bitCount = 5'h00;
							if (newCmd.inputSel != state_reg.inSel) begin
								state_next.restart = 1'b1;
							end
							state_next.inSel  = newCmd.inputSel;
							state_next.supply = (newCmd.inputSel == scrfe_pkg::CH_SUPPLY);
							if (newCmd.readDir && newCmd.streamRd
							    && newCmd.regSel == scrfe_pkg::ADDR_DATA) begin
								state_next.fsm       = scrfe_pkg::ST_STREAM;
								state_next.shiftOut  = dataValue;
								state_next.outActive = 1'b1;
							end else if (newCmd.readDir) begin
								state_next.fsm       = scrfe_pkg::ST_ACCESS;
								state_next.outActive = 1'b1;
								case (newCmd.regSel)
									scrfe_pkg::ADDR_COMMAND: state_next.shiftOut = {statusValue, 16'h0000};
									scrfe_pkg::ADDR_MODE:    state_next.shiftOut = {modeValue, 16'h0000};
									scrfe_pkg::ADDR_FILTER:  state_next.shiftOut = {filterValue, 16'h0000};
									default:                 state_next.shiftOut = dataValue;
								endcase
							end else if (newCmd.regSel == scrfe_pkg::ADDR_COMMAND) begin
								state_next.fsm = scrfe_pkg::ST_IDLE;
							end else begin
								state_next.fsm = scrfe_pkg::ST_ACCESS;
							end
						end
					end
					scrfe_pkg::ST_ACCESS: begin
						state_next.bitCount = state_reg.bitCount + 5'h01;
						if (state_reg.cmd[scrfe_pkg::POS_RW]) begin
							// read: done after the register length
							if (state_reg.bitCount == readLen - 5'h01) begin
								state_next.fsm       = scrfe_pkg::ST_IDLE;
								state_next.bitCount  = 5'h00;
								state_next.outActive = 1'b0;
								state_next.rdyN      = 1'b1;
							end
						end else if (state_reg.bitCount == scrfe_pkg::LEN_SHORT - 5'h01) begin
							// write of an 8-bit register completes
							state_next.wrStb    = 1'b1;
							state_next.wrAddr   = state_reg.cmd[scrfe_pkg::POS_RSHI:scrfe_pkg::POS_RSLO];
							state_next.wrData   = fullByte;
							state_next.fsm      = scrfe_pkg::ST_IDLE;
							state_next.bitCount = 5'h00;
						end
					end
					scrfe_pkg::ST_STREAM: begin
						// keep watching the input for an exit command
						state_next.bitCount = state_reg.bitCount + 5'h01;
						if (state_reg.bitCount == scrfe_pkg::LEN_SHORT - 5'h01) begin
							state_next.bitCount = 5'h00;
							if (fullByte[7:2] == scrfe_pkg::EXIT_PATTERN && !state_reg.rdyN) begin
								state_next.fsm       = scrfe_pkg::ST_IDLE;
								state_next.outActive = 1'b0;
							end
						end
						// framing stays on 8-bit boundaries counted from the stream command;
						// holding the count on leading zeros would swallow the two leading
						// zeros of the exit command, so it would never be seen
					end
					default: begin
						state_next.fsm = scrfe_pkg::ST_IDLE;
					end
				endcase
			end
			// each new result reloads the stream
			if (state_reg.fsm == scrfe_pkg::ST_STREAM && convDone) begin
				state_next.shiftOut = dataValue;
			end
			// 32 consecutive ones: reset the whole interface
			if (state_next.onesCount == scrfe_pkg::ONES_LIMIT) begin
				state_next           = '0;
				state_next.fsm       = scrfe_pkg::ST_IDLE;
				state_next.cmd       = scrfe_pkg::CMD_RESET;
				state_next.rdyN      = 1'b1;
				state_next.dout      = 1'b1;
				state_next.oe        = state_reg.oe;
				state_next.rstPulse  = 1'b1;
				state_next.restart   = (state_reg.inSel != scrfe_pkg::CH_DIFF);
			end
		end
	end

	// register the state; command register clears at reset
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_reg      <= '0;
			state_reg.fsm  <= scrfe_pkg::ST_IDLE;
			state_reg.cmd  <= scrfe_pkg::CMD_RESET;
			state_reg.rdyN <= 1'b1;
			state_reg.dout <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	// outputs straight from state flip-flops, except streamActive, which is decoded from the state
	assign doutRdy       = state_reg.dout;
	assign doutOe        = state_reg.oe;
	assign commandReg    = state_reg.cmd;
	assign inputSel      = state_reg.inSel;
	assign supplyMonitor = state_reg.supply;
	assign filterRestart = state_reg.restart;
	assign streamActive  = (state_reg.fsm == scrfe_pkg::ST_STREAM);
	assign writeStrobe   = state_reg.wrStb;
	assign writeAddr     = state_reg.wrAddr;
	assign writeData     = state_reg.wrData;
	assign partReset     = state_reg.rstPulse;
endmodule
`default_nettype wire

// ### bench/scrfe_host_model.sv
// host model: drives serial clock, serial input and chip select, reads data out
// assumes a 50 MHz bench clock, giving a 160 ns serial clock period
`timescale 1ns/1ps
`default_nettype none
module scrfe_host_model (
	input  wire logic clock,   // system clock, paces the serial clock
	input  wire logic doutRdy, // data out / ready pin from the device
	output logic      sclk,    // serial clock, idle high
	output logic      din,     // serial data to the device
	output logic      csN      // chip select, active low
);
	// idle: clock high, input low, device not selected
	initial begin
		sclk = 1'b1;
		din  = 1'b0;
		csN  = 1'b1;
	end
	// selects or releases the device, then lets the synchroniser settle
	task automatic sel(input logic v);
		@(posedge clock);
		csN <= v;
		repeat (4) @(posedge clock);
	endtask
	// shifts n bits msb first; new bit after the fall, device bit taken at the rise
	task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
		rx = 32'h0;
		for (int i = n - 1; i >= 0; i--) begin
			@(posedge clock);
			sclk <= 1'b0;
			din  <= tx[i];
			repeat (4) @(posedge clock);
			sclk <= 1'b1;
			rx = {rx[30:0], doutRdy};
			repeat (3) @(posedge clock);
		end
		din <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ### bench/scrfe_front_end_monitor.sv
// checker of the front end's ports: pin enable, command, channel, ready, resets
// assumes enable stays high, so every pin crosses in three clocks
`timescale 1ns/1ps
`default_nettype none
module scrfe_front_end_monitor (
	input wire logic       clock,         // system clock
	input wire logic       rst_n,         // reset, active low
	input wire logic       csN,           // chip select pin
	input wire logic       convDone,      // result ready pulse
	input wire logic       resultStale,   // result stale pulse
	input wire logic       doutRdy,       // data out / ready pin
	input wire logic       doutOe,        // pin enable
	input wire logic [7:0] commandReg,    // command register
	input wire logic [1:0] inputSel,      // channel
	input wire logic       supplyMonitor, // supply channel flag
	input wire logic       filterRestart, // restart pulse
	input wire logic       streamActive,  // continuous read flag
	input wire logic       writeStrobe,   // write pulse
	input wire logic       partReset      // full reset pulse
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	// chip select held for the synchroniser depth plus the output flop
	sequence s_sel_held; !csN [*4]; endsequence
	sequence s_free_held; csN [*4]; endsequence
	a_oe_when_sel: assert property (s_sel_held |-> doutOe)
		else $error("pin enable low while selected");
	a_oe_when_free: assert property (s_free_held |-> !doutOe)
		else $error("pin enable high while released");
	a_cmd_top_zero: assert property (commandReg[7] == 1'b0)
		else $error("command top bit set");
	a_supply_match: assert property (supplyMonitor == (inputSel == 2'h3))
		else $error("supply flag disagrees with channel");
	a_restart_on_change: assert property ($changed(inputSel) |-> ##[0:1] filterRestart)
		else $error("channel change without restart");
	a_restart_single: assert property (filterRestart |=> !filterRestart)
		else $error("restart longer than one cycle");
	a_write_single: assert property (writeStrobe |=> !writeStrobe)
		else $error("write strobe longer than one cycle");
	a_reset_clears: assert property (partReset |-> ##[0:2] (commandReg == 8'h00 && !streamActive))
		else $error("full reset left state behind");
	a_ready_on_done: assert property ((convDone && csN) |-> ##[1:2] !doutRdy)
		else $error("ready not low after result");
	a_ready_on_stale: assert property ((resultStale && csN) |-> ##[1:2] doutRdy)
		else $error("ready not high before update");
	a_stream_cmd: assert property ($rose(streamActive) |-> ##[0:1] (commandReg[5:2] == 4'hf))
		else $error("stream entered without stream command");
endmodule
bind scrfe_front_end scrfe_front_end_monitor scrfe_front_end_monitor_i (.clock(clock),
	.rst_n(rst_n), .csN(csN), .convDone(convDone), .resultStale(resultStale),
	.doutRdy(doutRdy), .doutOe(doutOe), .commandReg(commandReg), .inputSel(inputSel),
	.supplyMonitor(supplyMonitor), .filterRestart(filterRestart),
	.streamActive(streamActive), .writeStrobe(writeStrobe), .partReset(partReset));
`default_nettype wire

// ### bench/testbench.sv
// self-checking bench for the serial command front end
// assumes the host model paces the serial clock from the 50 MHz system clock
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
	$display("FAIL %s expected %h seen %h", nm, e, g); end end
module testbench;
	logic        clock, rst_n, enable, convDone, resultStale; // system side inputs
	logic        sclk, din, csN;                              // serial pins from host
	logic [7:0]  statusValue, modeValue, filterValue;         // register contents
	logic [23:0] dataValue;                                   // data register contents
	logic        doutRdy, doutOe, supplyMonitor, filterRestart, streamActive;
	logic        writeStrobe, partReset;                      // event outputs
	logic [7:0]  commandReg, writeData, cmd;                  // command and write byte
	logic [1:0]  inputSel, writeAddr;                         // channel and write address
	logic [31:0] seed = 32'he98a, rx, ex;                     // random state, read, expected
	logic [9:0]  wq[$];                                       // expected writes, oldest first
	logic [9:0]  wexp;                                        // write taken from the queue
	int          miscompares = 0, comparisons = 0, cycles = 0, restarts = 0, resets = 0, n;
	scrfe_front_end scrfe_front_end_i (.clock(clock), .rst_n(rst_n), .enable(enable),
		.sclk(sclk), .din(din), .csN(csN), .convDone(convDone), .resultStale(resultStale),
		.statusValue(statusValue), .modeValue(modeValue), .filterValue(filterValue),
		.dataValue(dataValue), .doutRdy(doutRdy), .doutOe(doutOe), .commandReg(commandReg),
		.inputSel(inputSel), .supplyMonitor(supplyMonitor), .filterRestart(filterRestart),
		.streamActive(streamActive), .writeStrobe(writeStrobe), .writeAddr(writeAddr),
		.writeData(writeData), .partReset(partReset));
	scrfe_host_model scrfe_host_model_i (.clock(clock), .doutRdy(doutRdy), .sclk(sclk),
		.din(din), .csN(csN));
	always #10 clock = ~clock;
	// next random word
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// one-cycle result pulse (k 0) or stale pulse (k 1), then settle
	task automatic pulse(input int k);
		@(posedge clock);
		if (k == 0) convDone <= 1'b1;
		else resultStale <= 1'b1;
		@(posedge clock);
		convDone    <= 1'b0;
		resultStale <= 1'b0;
		repeat (4) @(posedge clock);
	endtask
	task automatic idle(input int k);
		repeat (k) @(posedge clock);
	endtask
	task automatic close_out();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// write port against the queue, event counts, hang limit
	always @(posedge clock) begin
		cycles++;
		if (filterRestart === 1'b1) restarts++;
		if (partReset === 1'b1) resets++;
		if (writeStrobe === 1'b1) begin
			wexp = (wq.size() != 0) ? wq.pop_front() : 10'h3ff;
			`CHK("write", wexp, {writeAddr, writeData})
		end
		if (cycles == 20000) begin
			miscompares++;
			close_out();
		end
	end
	initial begin
		clock = 0; rst_n = 0; enable = 1; convDone = 0; resultStale = 0;
		statusValue = 8'h00; modeValue = 8'h00; filterValue = 8'h00; dataValue = 24'h0;
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
		idle(3);
		`CHK("cmd after reset", 8'h00, commandReg)
		`CHK("ready after reset", 1'b1, doutRdy)
		scrfe_host_model_i.sel(1'b0);
		// 31 leading ones hold the first position, then a mode write
		scrfe_host_model_i.xfer(32'h7fffffff, 31, rx);
		seed = lfsr(seed);
		wq.push_back({2'h1, seed[7:0]});
		scrfe_host_model_i.xfer({16'h0, 8'h10, seed[7:0]}, 16, rx);
		idle(4);
		`CHK("cmd mode write", 8'h10, commandReg)
		`CHK("no reset on 31 ones", 0, resets)
		`CHK("writes left", 0, wq.size())
		$display("test write done");
		// read every register, each with its own channel
		for (int a = 0; a < 4; a++) begin
			seed = lfsr(seed);
			statusValue <= seed[7:0];
			modeValue   <= seed[15:8];
			filterValue <= seed[23:16];
			dataValue   <= seed[31:8];
			pulse(0);
			cmd = 8'h08 | 8'(a * 17);
			n = (a == 3) ? 24 : 8;
			ex = (a == 0) ? 32'(statusValue) : (a == 1) ? 32'(modeValue) :
				(a == 2) ? 32'(filterValue) : 32'(dataValue);
			scrfe_host_model_i.xfer({cmd, 24'h0} >> (24 - n), 8 + n, rx);
			idle(4);
			`CHK("read data", ex, rx & ((32'h1 << n) - 1))
			`CHK("input select", a[1:0], inputSel)
			`CHK("supply monitor", (a == 3), supplyMonitor)
		end
		`CHK("filter restarts", 3, restarts)
		$display("test reads done");
		scrfe_host_model_i.sel(1'b1);
		pulse(0);
		`CHK("ready on done", 1'b0, doutRdy)
		pulse(1);
		`CHK("ready on stale", 1'b1, doutRdy)
		$display("test ready done");
		// continuous read, two bursts, exit while ready is low
		scrfe_host_model_i.sel(1'b0);
		scrfe_host_model_i.xfer(32'h3c, 8, rx);
		idle(4);
		`CHK("stream on", 1'b1, streamActive)
		for (int b = 0; b < 2; b++) begin
			seed = lfsr(seed);
			dataValue <= seed[23:0];
			pulse(0);
			scrfe_host_model_i.xfer(32'h0, 24, rx);
			`CHK("stream data", seed[23:0], rx[23:0])
		end
		pulse(0);
		scrfe_host_model_i.xfer(32'h38, 8, rx);
		idle(4);
		`CHK("stream off", 1'b0, streamActive)
		// stream again, then 32 ones force a full reset
		scrfe_host_model_i.xfer(32'h3d, 8, rx);
		idle(4);
		`CHK("single ended", 2'h1, inputSel)
		scrfe_host_model_i.xfer(32'hffffffff, 32, rx);
		idle(4);
		`CHK("full resets", 1, resets)
		`CHK("cmd cleared", 8'h00, commandReg)
		`CHK("stream cleared", 1'b0, streamActive)
		$display("test stream done");
		close_out();
	end
endmodule
`default_nettype wire
